// >>> core/gas_map.svh
// Address map, field positions and timing counts of the global register space.
`ifndef GAS_MAP_SVH
`define GAS_MAP_SVH

// ****************************************************************
// Global space layout
// ****************************************************************
`define GAS_SYS_AW 18
`define GAS_NPORT 16
`define GAS_BRIDGE_STRIDE 18'h02000
`define GAS_BRIDGE_LAST 18'h1E000
`define GAS_RSVD_BASE 18'h20000
`define GAS_SWITCH_BASE 18'h3E000
`define GAS_SWITCH_TAG 5'h1F

// ****************************************************************
// Offsets inside a bridge region (12 bit) and the switch region (13 bit)
// ****************************************************************
`define GAS_EXT_ADDR_OFS 12'hFF0
`define GAS_EXT_DATA_OFS 12'hFF4
`define GAS_IND_ADDR_OFS 12'hFF8
`define GAS_IND_DATA_OFS 12'hFFC
`define GAS_PHY_STATE_OFS 12'h800
`define GAS_RETRAIN_BIT 1
`define GAS_GUARD_OFS 13'h0100
`define GAS_SWCTL_OFS 13'h0200
`define GAS_MODE_W 4

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define GAS_GUARD_RESET 16'h0000
`define GAS_CLK_NS 10
`define GAS_SIDE_DELAY_NS 1000000
`define GAS_SIDE_DELAY_CYC (`GAS_SIDE_DELAY_NS / `GAS_CLK_NS)

`endif

// >>> core/gas_pkg.sv
// Types shared by the global register space access block.
package gas_pkg;
	`include "gas_map.svh"

	typedef enum logic [2:0] {
		GAS_ST_IDLE = 3'b000,
		GAS_ST_GRANT = 3'b001,
		GAS_ST_DECODE = 3'b010,
		GAS_ST_READ = 3'b011,
		GAS_ST_RESP = 3'b100
	} gas_state_type;

	typedef enum logic [1:0] {
		GAS_SRC_CFG = 2'b00,
		GAS_SRC_AXW = 2'b01,
		GAS_SRC_AXR = 2'b10
	} gas_src_type;

	// Whole state of the access engine.
	typedef struct packed {
		gas_state_type st;
		gas_src_type src;
		logic wr;
		logic oob;
		logic indirect;
		logic ind;
		logic [3:0] port;
		logic [17:0] sys;
		logic [31:0] wdata;
		logic [3:0] be;
		logic [31:0] imm;
		logic [15:0] guard;
		logic [15:0][15:0] iaddr;
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic rvalid;
		logic [31:0] rdata;
		logic cfg_ready;
		logic cfg_done;
		logic [31:0] cfg_rdata;
		logic dly_busy;
		logic dly_mode;
		logic [19:0] dly_cnt;
		logic [3:0] dly_port;
		logic [3:0] dly_val;
		logic retrain_pulse;
		logic [3:0] retrain_port;
		logic mode_pulse;
		logic [3:0] mode_port;
		logic [3:0] mode_val;
	} gas_state_s_type;
endpackage : gas_pkg

// >>> core/gas_mem.sv
// Word memory with byte write enables behind the global register space.
`timescale 1ns/1ps
module gas_mem #(
	parameter int ADDR_W = 15
) (
	input wire logic clk_sys,
	input wire logic ce,
	input wire logic en,
	input wire logic we,
	input wire logic [3:0] be,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	// ****************************************************************
	// Byte lanes
	// ****************************************************************
	// Each lane owns its byte array and its slice of the read register.
	// That way no storage is written from more than one process.
	for (genvar b = 0; b < 4; b++) begin : g_lane
		logic [7:0] mem [0:(1<<ADDR_W)-1];
		// Lane write under its own enable; read comes one cycle after the enable.
		always_ff @(posedge clk_sys) begin
			if (ce && en && we && be[b]) begin
				mem[addr] <= wdata[8*b +: 8];
			end
			if (ce && en && !we) begin
				rdata[8*b +: 8] <= mem[addr];
			end
		end
	end
endmodule : gas_mem

// >>> core/gas_access.sv
// Global register space decoder with per-port indirect access and deferred side effects.
// Overview of operation
// - All registers live in one 256 KB space with 18-bit system addresses.
// - Port n bridge region starts at n times 0x02000, port 15 at 0x1E000.
// - Each bridge register set fills 4 KB of its port slot.
// - Switch registers sit in 8 KB at 0x3E000; the rest is reserved.
// - EEPROM and SMBus accesses use system addresses directly.
// - Bridge registers answer configuration requests only in switch port mode.
// - Configuration offset equals the register offset inside the port region.
// - Any function reaches the whole space through its indirect registers.
// - Reading indirect data returns the register picked by the stored address.
// - Writing indirect data updates the register picked by the stored address.
// - Indirect access reaches every register except the extended window pair, other ports included.
// - Per-port guard bit makes both indirect registers read zero, read-only.
// - SMBus and EEPROM accesses ignore the guard bits.
// - Completion of a side-effect write is returned before the action.
// - Side-effect action waits 1 ms after the completion.
// - Deferral applies to retrain bit and switch port control mode field; the code arms it only for configuration requests, bus writes trigger no action.
// - Reserved reads return don't-care data; reserved writes complete harmlessly.
// - Indirect access may not reach the extended configuration window registers.
`timescale 1ns/1ps
module gas_access
	import gas_pkg::*;
#(
	parameter int SIDE_DELAY_CYC = `GAS_SIDE_DELAY_CYC,
	parameter int MEM_AW = 15
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cfg_valid,
	output logic cfg_ready,
	input wire logic [3:0] cfg_port,
	input wire logic cfg_write,
	input wire logic [11:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [3:0] cfg_be,
	input wire logic [15:0] port_switch_mode,
	output logic cfg_done,
	output logic [31:0] cfg_rdata,
	output logic retrain_pulse,
	output logic [3:0] retrain_port,
	output logic mode_apply_pulse,
	output logic [3:0] mode_apply_port,
	output logic [3:0] mode_apply_value
);
	gas_state_s_type s;
	gas_state_s_type next;
	logic mem_en;
	logic mem_we;
	logic [MEM_AW-1:0] mem_idx;
	logic [31:0] mem_rdata;
	logic arm;
	logic is_bridge;
	logic is_switch;
	logic mapped;
	logic [11:0] boff;

	// ****************************************************************
	// Backing store
	// ****************************************************************
	gas_mem #(.ADDR_W(MEM_AW)) u_mem (
		.clk_sys(clk_sys),
		.ce(ce),
		.en(mem_en),
		.we(mem_we),
		.be(s.be),
		.addr(mem_idx),
		.wdata(s.wdata),
		.rdata(mem_rdata)
	);

	// ****************************************************************
	// Region decode of the held system address
	// ****************************************************************
	// 18-bit space decode
	always_comb begin
		is_bridge = !s.oob && !s.sys[17];
		is_switch = !s.oob && (s.sys[17:13] == `GAS_SWITCH_TAG);
		boff = s.sys[11:0];
		// upper 4 KB of each slot unmapped
		mapped = (is_bridge && !s.sys[12]) || is_switch;
		// port slots first, the switch region packs above them
		if (is_bridge) begin
			mem_idx = MEM_AW'({1'b0, s.sys[16:13], s.sys[11:2]});
		end else begin
			mem_idx = MEM_AW'({1'b1, 3'b000, s.sys[12:2]});
		end
	end

	// ****************************************************************
	// Access engine
	// ****************************************************************
	// One access at a time; configuration requests win over the bus.
	always_comb begin
		next = s;
		next.retrain_pulse = 1'b0;
		next.mode_pulse = 1'b0;
		next.cfg_done = 1'b0;
		next.cfg_ready = 1'b0;
		next.awready = 1'b0;
		next.wready = 1'b0;
		next.arready = 1'b0;
		mem_en = 1'b0;
		mem_we = 1'b0;
		arm = 1'b0;
		unique case (s.st)
			GAS_ST_IDLE: begin
				if (cfg_valid) begin
					next.cfg_ready = 1'b1;
					next.src = GAS_SRC_CFG;
					next.st = GAS_ST_GRANT;
				end else if (s_axi_awvalid && s_axi_wvalid) begin
					next.awready = 1'b1;
					next.wready = 1'b1;
					next.src = GAS_SRC_AXW;
					next.st = GAS_ST_GRANT;
				end else if (s_axi_arvalid) begin
					next.arready = 1'b1;
					next.src = GAS_SRC_AXR;
					next.st = GAS_ST_GRANT;
				end
			end
			GAS_ST_GRANT: begin
				next.imm = 32'h0000_0000;
				next.indirect = 1'b0;
				next.ind = 1'b0;
				next.oob = 1'b0;
				next.st = GAS_ST_DECODE;
				if (s.src == GAS_SRC_CFG) begin
					next.port = cfg_port;
					next.wr = cfg_write;
					next.wdata = cfg_wdata;
					next.be = cfg_be;
					next.sys = 18'(cfg_port) * `GAS_BRIDGE_STRIDE + 18'(cfg_addr);
					if (!port_switch_mode[cfg_port]) begin
						// no bridge function outside switch modes
						next.st = GAS_ST_RESP;
					end else if (cfg_addr == `GAS_IND_ADDR_OFS) begin
						next.ind = 1'b1;
						next.st = GAS_ST_RESP;
						if (!s.guard[cfg_port]) begin
							if (cfg_write) begin
								next.iaddr[cfg_port] = cfg_wdata[17:2];
							end else begin
								next.imm = {14'h0000, s.iaddr[cfg_port], 2'b00};
							end
						end
					end else if (cfg_addr == `GAS_IND_DATA_OFS) begin
						next.ind = 1'b1;
						if (s.guard[cfg_port]) begin
							next.st = GAS_ST_RESP;
						end else begin
							// any function reaches the whole space
							next.sys = {s.iaddr[cfg_port], 2'b00};
							next.indirect = 1'b1;
						end
					end
				end else if (s.src == GAS_SRC_AXW) begin
					next.sys = s_axi_awaddr[17:0];
					next.oob = |s_axi_awaddr[31:18];
					next.wr = 1'b1;
					next.wdata = s_axi_wdata;
					next.be = s_axi_wstrb;
				end else begin
					next.sys = s_axi_araddr[17:0];
					next.oob = |s_axi_araddr[31:18];
					next.wr = 1'b0;
				end
			end
			GAS_ST_DECODE: begin
				next.st = GAS_ST_RESP;
				if (s.indirect && is_bridge &&
					(boff == `GAS_EXT_ADDR_OFS || boff == `GAS_EXT_DATA_OFS)) begin
					next.imm = 32'h0000_0000;
				end else if (is_bridge && !s.sys[12] && boff == `GAS_IND_ADDR_OFS) begin
					// system path ignores the guard bits
					if (s.wr) begin
						next.iaddr[s.sys[16:13]] = s.wdata[17:2];
					end else begin
						next.imm = {14'h0000, s.iaddr[s.sys[16:13]], 2'b00};
					end
				end else if (is_switch && s.sys[12:0] == `GAS_GUARD_OFS) begin
					if (s.wr && s.be[0]) begin
						next.guard[7:0] = s.wdata[7:0];
					end
					if (s.wr && s.be[1]) begin
						next.guard[15:8] = s.wdata[15:8];
					end
					next.imm = {16'h0000, s.guard};
				end else if (mapped) begin
					mem_en = 1'b1;
					mem_we = s.wr;
					if (!s.wr) begin
						next.st = GAS_ST_READ;
					end
				end
				// reserved space reads zero and drops writes
				// retrain bit and port mode writes from configuration requests are deferred
				if (s.wr && s.src == GAS_SRC_CFG && is_bridge && !s.sys[12] &&
					boff == `GAS_PHY_STATE_OFS && s.be[0] && s.wdata[`GAS_RETRAIN_BIT]) begin
					arm = 1'b1;
					next.dly_mode = 1'b0;
					next.dly_port = s.sys[16:13];
				end
				if (s.wr && s.src == GAS_SRC_CFG && is_switch && s.be[0] &&
					s.sys[12:6] == 7'(`GAS_SWCTL_OFS >> 6)) begin
					arm = 1'b1;
					next.dly_mode = 1'b1;
					next.dly_port = s.sys[5:2];
					next.dly_val = s.wdata[`GAS_MODE_W-1:0];
				end
			end
			GAS_ST_READ: begin
				next.imm = mem_rdata;
				next.st = GAS_ST_RESP;
			end
			GAS_ST_RESP: begin
				if (s.src == GAS_SRC_CFG) begin
					next.st = GAS_ST_IDLE;
				end else if (s.src == GAS_SRC_AXW && s_axi_bready) begin
					next.bvalid = 1'b0;
					next.st = GAS_ST_IDLE;
				end else if (s.src == GAS_SRC_AXR && s_axi_rready) begin
					next.rvalid = 1'b0;
					next.st = GAS_ST_IDLE;
				end
			end
			default: begin
				next.st = GAS_ST_IDLE;
			end
		endcase
		// Answers rise on entry to the response state, never before.
		if (next.st == GAS_ST_RESP && s.st != GAS_ST_RESP) begin
			if (s.src == GAS_SRC_CFG) begin
				next.cfg_done = 1'b1;
				next.cfg_rdata = next.imm;
			end else if (s.src == GAS_SRC_AXW) begin
				next.bvalid = 1'b1;
			end else begin
				next.rvalid = 1'b1;
				next.rdata = next.imm;
			end
		end
		// action fires a full delay after the completion
		if (arm) begin
			next.dly_busy = 1'b1;
			next.dly_cnt = 20'(SIDE_DELAY_CYC);
		end else if (s.dly_busy) begin
			if (s.dly_cnt == 20'h00001) begin
				next.dly_busy = 1'b0;
				next.retrain_pulse = !s.dly_mode;
				next.retrain_port = s.dly_port;
				next.mode_pulse = s.dly_mode;
				next.mode_port = s.dly_port;
				next.mode_val = s.dly_val;
			end else begin
				next.dly_cnt = s.dly_cnt - 20'h00001;
			end
		end
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s <= '0;
			s.st <= GAS_ST_IDLE;
			s.guard <= `GAS_GUARD_RESET;
		end else if (ce) begin
			s <= next;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_arready = s.arready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = 2'b00;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = 2'b00;
	assign cfg_ready = s.cfg_ready;
	assign cfg_done = s.cfg_done;
	assign cfg_rdata = s.cfg_rdata;
	assign retrain_pulse = s.retrain_pulse;
	assign retrain_port = s.retrain_port;
	assign mode_apply_pulse = s.mode_pulse;
	assign mode_apply_port = s.mode_port;
	assign mode_apply_value = s.mode_val;

	// ****************************************************************
	// Checks
	// ****************************************************************
	logic [20:0] age;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			age <= '0;
		end else if (ce) begin
			age <= arm ? 21'h000000 : age + 21'(s.dly_busy);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence seq_arm;
		$rose(s.dly_busy);
	endsequence

	AST_DONE_BEFORE_ACTION: assert property (seq_arm |-> cfg_done)
		else $error("side effect armed without a completion");
	AST_DELAY_LENGTH: assert property ((retrain_pulse || mode_apply_pulse) |->
		age == 21'(SIDE_DELAY_CYC))
		else $error("side effect fired at the wrong time");
	AST_GUARD_READS_ZERO: assert property ((cfg_done && s.ind && s.guard[s.port]) |->
		cfg_rdata == 32'h0000_0000)
		else $error("guarded indirect register read non-zero");
	AST_GUARD_DROPS_WRITE: assert property ((ce && s.st == GAS_ST_GRANT &&
		s.src == GAS_SRC_CFG && s.guard[cfg_port] &&
		(cfg_addr == `GAS_IND_ADDR_OFS || cfg_addr == `GAS_IND_DATA_OFS)) |=>
		s.iaddr == $past(s.iaddr) && s.st == GAS_ST_RESP)
		else $error("guarded indirect access was not dropped");
	AST_EXT_BLOCKED: assert property (mem_en |-> !(s.indirect && is_bridge &&
		(boff == `GAS_EXT_ADDR_OFS || boff == `GAS_EXT_DATA_OFS)))
		else $error("indirect access reached the extended window");
	AST_NO_RESERVED_WRITE: assert property (mem_we |-> mapped)
		else $error("write reached reserved space");
	AST_BRIDGE_SLOT: assert property ((mem_en && !s.sys[17]) |->
		mem_idx[13:10] == s.sys[16:13] && !s.sys[12])
		else $error("bridge access left its port slot");
	AST_READ_RETURN: assert property ((ce && s.st == GAS_ST_READ) |=>
		s.st == GAS_ST_RESP && s.imm == $past(mem_rdata))
		else $error("read data not taken from the store");
	AST_MODE_GATE: assert property ((ce && s.st == GAS_ST_GRANT && s.src == GAS_SRC_CFG &&
		!port_switch_mode[cfg_port]) |=> s.st == GAS_ST_RESP ##1 cfg_rdata == 32'h0)
		else $error("bridge answered outside switch mode");
endmodule : gas_access

// >>> bench/gas_cfg_host.sv
// Configuration requester model that drives the block's configuration port.
`timescale 1ns/1ps
module gas_cfg_host (
	input wire logic clk_sys,
	output logic cfg_valid,
	input wire logic cfg_ready,
	output logic [3:0] cfg_port,
	output logic cfg_write,
	output logic [11:0] cfg_addr,
	output logic [31:0] cfg_wdata,
	output logic [3:0] cfg_be,
	input wire logic cfg_done,
	input wire logic [31:0] cfg_rdata
);
	// Idle cycles before each request, so both prompt and slow requesters are seen.
	int slow = 0;
	initial begin
		cfg_valid = 1'b0;
		cfg_port = 4'h0;
		cfg_write = 1'b0;
		cfg_addr = 12'h000;
		cfg_wdata = 32'h00000000;
		cfg_be = 4'hF;
	end
	task automatic req(input logic w, input logic [3:0] p, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		repeat (slow) @(posedge clk_sys);
		cfg_valid <= 1'b1;
		cfg_write <= w;
		cfg_port <= p;
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_be <= 4'hF;
		do @(posedge clk_sys); while (cfg_ready !== 1'b1);
		// Released fields show the inverse, so a late sample cannot pass by luck.
		cfg_valid <= 1'b0;
		cfg_write <= ~w;
		cfg_port <= ~p;
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
		cfg_be <= 4'h0;
		do @(posedge clk_sys); while (cfg_done !== 1'b1);
		q = cfg_rdata;
	endtask : req
endmodule : gas_cfg_host

// >>> bench/tb_global_register_space_access.sv
// Self-checking testbench of the global register space access block.
`timescale 1ns/1ps
`include "gas_map.svh"
module tb_global_register_space_access;
	import gas_pkg::*;
	localparam int SDLY = 20;
	logic clk_sys = 1'b0, resetn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic cfg_valid, cfg_ready, cfg_write, cfg_done;
	logic [3:0] cfg_port, cfg_be, rt_port, md_port, md_val;
	logic [11:0] cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, q;
	logic [15:0] psm = 16'hFFFF;
	logic rt_pulse, md_pulse;
	int n_errors = 0, samples_checked = 0, cyc = 0, n;
	always #5 clk_sys = ~clk_sys;
	// ****************************************************************
	// Design and requester model
	// ****************************************************************
	gas_access #(.SIDE_DELAY_CYC(SDLY)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_port(cfg_port),
		.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
		.port_switch_mode(psm), .cfg_done(cfg_done), .cfg_rdata(cfg_rdata),
		.retrain_pulse(rt_pulse), .retrain_port(rt_port), .mode_apply_pulse(md_pulse),
		.mode_apply_port(md_port), .mode_apply_value(md_val));
	gas_cfg_host i_host (.clk_sys(clk_sys), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
		.cfg_port(cfg_port), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_done(cfg_done), .cfg_rdata(cfg_rdata));
	// ****************************************************************
	// Bus tasks and comparison
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Address and data go up together; each drops on its own ready.
	task automatic aw(input logic [31:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'h0, {30'h0, bresp});
		@(posedge clk_sys);
	endtask : aw
	task automatic ar(input logic [31:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk("rresp", 32'h0, {30'h0, rresp});
		@(posedge clk_sys);
	endtask : ar
	// Edges from completion until the chosen deferred pulse is seen.
	task automatic cnt(input logic m, output int k);
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while ((m ? md_pulse : rt_pulse) !== 1'b1);
	endtask : cnt
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	// A hang counts as a mismatch and ends the run.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		aw(32'h06010, 32'hA5A50003);
		ar(32'h06010, q);
		chk("sys word", 32'hA5A50003, q);
		i_host.req(1'b0, 4'h3, 12'h010, 32'h0, q);
		chk("cfg word", 32'hA5A50003, q);
		psm <= 16'hFFF7;
		i_host.req(1'b0, 4'h3, 12'h010, 32'h0, q);
		chk("cfg off mode", 32'h0, q);
		psm <= 16'hFFFF;
		$display("direct access test done");
		i_host.req(1'b1, 4'h0, `GAS_IND_ADDR_OFS, 32'h1E010, q);
		i_host.req(1'b0, 4'h0, `GAS_IND_ADDR_OFS, 32'h0, q);
		chk("ind addr", 32'h1E010, q);
		i_host.req(1'b1, 4'h0, `GAS_IND_DATA_OFS, 32'h12345678, q);
		ar(32'h1E010, q);
		chk("ind write", 32'h12345678, q);
		i_host.req(1'b0, 4'h0, `GAS_IND_DATA_OFS, 32'h0, q);
		chk("ind read", 32'h12345678, q);
		$display("indirect test done");
		aw(32'h3E100, 32'h1);
		ar(32'h3E100, q);
		chk("guard", 32'h1, q);
		i_host.req(1'b0, 4'h0, `GAS_IND_ADDR_OFS, 32'h0, q);
		chk("guarded addr", 32'h0, q);
		i_host.req(1'b0, 4'h0, `GAS_IND_DATA_OFS, 32'h0, q);
		chk("guarded data", 32'h0, q);
		i_host.req(1'b1, 4'h0, `GAS_IND_DATA_OFS, 32'h0000DEAD, q);
		ar(32'h1E010, q);
		chk("guarded write", 32'h12345678, q);
		ar(32'h00FF8, q);
		chk("sys ind addr", 32'h1E010, q);
		aw(32'h3E100, 32'h0);
		$display("guard test done");
		aw(32'h20000, 32'hFFFFFFFF);
		ar(32'h20000, q);
		chk("reserved", 32'h0, q);
		aw(32'h07000, 32'hFFFFFFFF);
		ar(32'h07000, q);
		chk("upper slot", 32'h0, q);
		ar(32'h40000, q);
		chk("beyond 18b", 32'h0, q);
		$display("reserved test done");
		i_host.slow = 2;
		aw(32'h02FF0, 32'h55);
		i_host.req(1'b1, 4'h1, `GAS_IND_ADDR_OFS, 32'h02FF0, q);
		i_host.req(1'b0, 4'h1, `GAS_IND_DATA_OFS, 32'h0, q);
		chk("ext window", 32'h0, q);
		i_host.slow = 0;
		$display("window test done");
		i_host.req(1'b1, 4'h2, `GAS_PHY_STATE_OFS, 32'h2, q);
		cnt(1'b0, n);
		chk("retrain delay", SDLY, n);
		chk("retrain port", 32'h2, {28'h0, rt_port});
		i_host.req(1'b1, 4'h1, `GAS_IND_ADDR_OFS, 32'h3E214, q);
		i_host.req(1'b1, 4'h1, `GAS_IND_DATA_OFS, 32'h3, q);
		cnt(1'b1, n);
		chk("mode delay", SDLY, n);
		chk("mode port", 32'h53, {24'h0, md_port, md_val});
		$display("side effect test done");
		stop_test();
	end
endmodule : tb_global_register_space_access
